// ---- rtl/ppic_pkg.sv ----
// Constants, register indexes and source map of the posted/pending interrupt controller
package ppic_pkg;

    localparam int NUM_GROUPS = 3;
    localparam int GROUP_W = 8;
    localparam int NUM_PRIO = 26;
    localparam int PRIO_W = 5;

    // Register indexes; byte address is four times the index
    localparam logic [7:0] IDX_CLEAR0 = 8'hda;
    localparam logic [7:0] IDX_CLEAR1 = 8'hdb;
    localparam logic [7:0] IDX_CLEAR2 = 8'hdc;
    localparam logic [7:0] IDX_MASK3 = 8'hde;
    localparam logic [7:0] IDX_MASK2 = 8'hdf;
    localparam logic [7:0] IDX_MASK0 = 8'he0;
    localparam logic [7:0] IDX_MASK1 = 8'he1;

    // Implemented bits of each clear/mask group
    localparam logic [7:0] GROUP_VALID [NUM_GROUPS] = '{8'hff, 8'h7f, 8'h16};
    localparam int SW_POST_BIT = 7;
    localparam logic [7:0] MASK3_VALID = 8'h80;
    localparam logic [7:0] REG_RESET = 8'h00;

    // Priority of each group bit; 0 marks a reserved bit
    localparam logic [4:0] PRIO_MAP [NUM_GROUPS][GROUP_W] = '{
        '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07, 5'h19, 5'h06},
        '{5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h00},
        '{5'h00, 5'h11, 5'h12, 5'h00, 5'h14, 5'h00, 5'h00, 5'h00}
    };

    // Group and bit of the edge-triggered port inputs
    localparam int NUM_PORTS = 3;
    localparam int PORT_GROUP [NUM_PORTS] = '{0, 0, 2};
    localparam int PORT_BIT [NUM_PORTS] = '{4, 7, 4};

    // Flag register and dispatch sequence
    localparam int FLAG_IRQ_ENABLE_BIT = 0;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [3:0] DISPATCH_CYCLES = 4'hd;
    localparam logic [3:0] STEP_PUSH_PC_HIGH = 4'h0;
    localparam logic [3:0] STEP_PUSH_PC_LOW = 4'h1;
    localparam logic [3:0] STEP_PUSH_FLAGS = 4'h2;
    localparam logic [3:0] STEP_CLEAR_FLAGS = 4'h3;
    localparam logic [3:0] STEP_LOAD_PC = DISPATCH_CYCLES - 4'h1;
    localparam int LONG_JUMP_CYCLES = 7;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic {PPIC_IDLE, PPIC_DISPATCH} ppic_state_type;

endpackage

// ---- rtl/ppic_prio_enc.sv ----
// Priority encoder: lowest set index wins
`timescale 1ns/1ps
`default_nettype none
module ppic_prio_enc #(
    parameter int N = 26,
    parameter int W = 5
) (
    input wire logic [N-1:0] pending,
    output logic any,
    output logic [W-1:0] index
);
    always_comb
    begin
        any = 1'b0;
        index = '0;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (pending[i])
            begin
                any = 1'b1;
                index = W'(i);
            end
        end
    end
endmodule // ppic_prio_enc
`default_nettype wire

// ---- rtl/ppic_ctrl.sv ----
// Posted/pending interrupt controller with CPU dispatch sequencer and AXI4-Lite registers
// Function
// - Event latches posted flag until taken or cleared.
// - Posted flag pends only while its mask bit is set.
// - Highest priority pending taken only with global enable.
// - Clearing a mask keeps posted flags and posting.
// - Active on event, unmasking or global enable rising.
// - Port interrupts post on edges, not levels.
// - Dispatch of 13 cycles follows instruction end.
// - Dispatch pushes PC high, PC low, then flags.
// - Dispatch then clears the flag register.
// - PC high loads zero, PC low the vector.
// - Return restores flags and global enable.
// - After return, pending requests dispatch first.
// - Enable set in a handler allows nesting at once.
// - Latency is instruction rest plus 13 plus 7.
// - Clear registers read the posted flags.
// - Clear group 0: port1, sleep, ext1, port0, rx, tx, ext0, power.
// - Clear group 1: interval, 1 ms, active, reset, three endpoints.
// - Clear group 2: port 2, ext input 2, counter wrap.
// - Post disabled: written zero clears, one ignored.
// - Post enabled: written one posts the source.
// - Each mask bit of groups 0 to 2 acts only on its own source.
// - Vector of priority n is n times four.
`timescale 1ns/1ps
`default_nettype none
module ppic_ctrl #(
    parameter int ADDR_W = 12
) (
    input wire logic clk,
    input wire logic resetn,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Sources: one-cycle pulses from on-chip logic, group-major
    input wire logic [23:0] hw_event,
    // Port interrupt pins, asynchronous
    input wire logic [2:0] port_irq_pin,
    // CPU core side
    input wire logic cpu_instr_end,
    input wire logic [15:0] cpu_program_counter,
    input wire logic cpu_flag_wr,
    input wire logic [7:0] cpu_flag_wdata,
    input wire logic return_from_irq_instr,
    input wire logic [7:0] cpu_popped_flags,
    output logic [7:0] cpu_flags,
    output logic dispatch_busy,
    output logic stack_push,
    output logic [7:0] stack_push_data,
    output logic pc_load,
    output logic [15:0] pc_load_value
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
        logic [7:0] idx;
        idx = a[9:2];
        reg_hit = (a[ADDR_W-1:10] == '0) && (a[1:0] == 2'h0) &&
            ((idx >= ppic_pkg::IDX_CLEAR0 && idx <= ppic_pkg::IDX_CLEAR2) ||
             (idx >= ppic_pkg::IDX_MASK3 && idx <= ppic_pkg::IDX_MASK1));
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    logic [7:0] posted_ff [3];
    logic [7:0] nxt_posted [3];
    logic [7:0] source_mask_regs_ff [3];
    logic [7:0] nxt_source_mask_regs [3];
    logic software_post_enable_bit_ff;
    logic nxt_software_post_enable_bit;
    logic [2:0] port_sync1_ff, port_sync2_ff, port_prev_ff;

    logic aw_held_ff, nxt_aw_held, w_held_ff, nxt_w_held;
    logic [ADDR_W-1:0] aw_addr_ff, nxt_aw_addr;
    logic [7:0] w_byte_ff, nxt_w_byte;
    logic w_lane0_ff, nxt_w_lane0;
    logic awready_ff, nxt_awready, wready_ff, nxt_wready;
    logic bvalid_ff, nxt_bvalid, arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;

    ppic_pkg::ppic_state_type state_ff, nxt_state;
    logic [3:0] step_ff, nxt_step;
    logic [15:0] pc_snap_ff, nxt_pc_snap;
    logic [7:0] flags_snap_ff, nxt_flags_snap;
    logic [7:0] vector_ff, nxt_vector;
    logic [7:0] flags_ff, nxt_flags;
    logic busy_ff, nxt_busy, push_ff, nxt_push, load_ff, nxt_load;
    logic [7:0] push_data_ff, nxt_push_data;
    logic [15:0] load_value_ff, nxt_load_value;

    ////////////////////////////////////////////////////////////////////////////
    // Port edge detection

    logic [2:0] port_edge;

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            port_sync1_ff <= 3'h0;
            port_sync2_ff <= 3'h0;
            port_prev_ff <= 3'h0;
        end
        else
        begin
            port_sync1_ff <= port_irq_pin;
            port_sync2_ff <= port_sync1_ff;
            port_prev_ff <= port_sync2_ff;
        end
    end

    // Either edge posts; a held level posts only once
    assign port_edge = port_sync2_ff ^ port_prev_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Pending vector and priority selection

    logic [ppic_pkg::NUM_PRIO-1:0] pending_prio;
    logic any_pending;
    logic [ppic_pkg::PRIO_W-1:0] sel_prio;
    logic [7:0] eff_flags;
    logic take;

    always_comb
    begin
        pending_prio = '0;
        for (int g = 0; g < ppic_pkg::NUM_GROUPS; g++)
        begin
            for (int b = 0; b < ppic_pkg::GROUP_W; b++)
            begin
                if (ppic_pkg::PRIO_MAP[g][b] != 5'h00)
                begin
                    // Only the bit's own mask gates it
                    pending_prio[ppic_pkg::PRIO_MAP[g][b]] =
                        posted_ff[g][b] & source_mask_regs_ff[g][b];
                end
            end
        end
    end

    ppic_prio_enc #(
        .N(ppic_pkg::NUM_PRIO),
        .W(ppic_pkg::PRIO_W)
    ) u_enc (
        .pending(pending_prio),
        .any(any_pending),
        .index(sel_prio)
    );

    // Flags as they stand at the end of this cycle, so a return or an enable write
    // in the closing instruction lets the next request in without a gap
    always_comb
    begin
        eff_flags = flags_ff;
        if (return_from_irq_instr)
        begin
            eff_flags = cpu_popped_flags;
        end
        else if (cpu_flag_wr)
        begin
            eff_flags = cpu_flag_wdata;
        end
    end

    assign take = (state_ff == ppic_pkg::PPIC_IDLE) && cpu_instr_end && any_pending &&
        eff_flags[ppic_pkg::FLAG_IRQ_ENABLE_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Posted flags and masks

    logic wr_fire;
    logic [7:0] wr_idx;

    assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
    assign wr_idx = aw_addr_ff[9:2];

    always_comb
    begin
        logic [7:0] hw, sw_clr, sw_post, take_clr;
        hw = 8'h00;
        sw_clr = 8'h00;
        sw_post = 8'h00;
        take_clr = 8'h00;
        nxt_software_post_enable_bit = software_post_enable_bit_ff;
        for (int g = 0; g < ppic_pkg::NUM_GROUPS; g++)
        begin
            hw = hw_event[g*8 +: 8];
            for (int p = 0; p < ppic_pkg::NUM_PORTS; p++)
            begin
                if (ppic_pkg::PORT_GROUP[p] == g)
                begin
                    hw[ppic_pkg::PORT_BIT[p]] = hw[ppic_pkg::PORT_BIT[p]] | port_edge[p];
                end
            end
            sw_clr = 8'h00;
            sw_post = 8'h00;
            if (wr_fire && w_lane0_ff && reg_hit(aw_addr_ff) &&
                wr_idx == ppic_pkg::IDX_CLEAR0 + 8'(g))
            begin
                if (software_post_enable_bit_ff)
                begin
                    sw_post = w_byte_ff;
                end
                else
                begin
                    sw_clr = ~w_byte_ff;
                end
            end
            for (int b = 0; b < ppic_pkg::GROUP_W; b++)
            begin
                take_clr[b] = take && ppic_pkg::PRIO_MAP[g][b] == sel_prio;
            end
            // Posting beats any clear in the same cycle
            nxt_posted[g] = ((posted_ff[g] & ~sw_clr & ~take_clr) | hw | sw_post) &
                ppic_pkg::GROUP_VALID[g];
            nxt_source_mask_regs[g] = source_mask_regs_ff[g];
        end
        if (wr_fire && w_lane0_ff && reg_hit(aw_addr_ff))
        begin
            unique case (wr_idx)
                ppic_pkg::IDX_MASK0: nxt_source_mask_regs[0] = w_byte_ff;
                ppic_pkg::IDX_MASK1: nxt_source_mask_regs[1] =
                    w_byte_ff & ppic_pkg::GROUP_VALID[1];
                ppic_pkg::IDX_MASK2: nxt_source_mask_regs[2] =
                    w_byte_ff & ppic_pkg::GROUP_VALID[2];
                ppic_pkg::IDX_MASK3: nxt_software_post_enable_bit =
                    w_byte_ff[ppic_pkg::SW_POST_BIT];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            for (int g = 0; g < ppic_pkg::NUM_GROUPS; g++)
            begin
                posted_ff[g] <= ppic_pkg::REG_RESET;
                source_mask_regs_ff[g] <= ppic_pkg::REG_RESET;
            end
            software_post_enable_bit_ff <= 1'b0;
        end
        else
        begin
            posted_ff <= nxt_posted;
            source_mask_regs_ff <= nxt_source_mask_regs;
            software_post_enable_bit_ff <= nxt_software_post_enable_bit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave

    function automatic logic [7:0] read_byte(input logic [7:0] idx);
        unique case (idx)
            ppic_pkg::IDX_CLEAR0: read_byte = posted_ff[0];
            ppic_pkg::IDX_CLEAR1: read_byte = posted_ff[1];
            ppic_pkg::IDX_CLEAR2: read_byte = posted_ff[2];
            ppic_pkg::IDX_MASK0: read_byte = source_mask_regs_ff[0];
            ppic_pkg::IDX_MASK1: read_byte = source_mask_regs_ff[1];
            ppic_pkg::IDX_MASK2: read_byte = source_mask_regs_ff[2];
            ppic_pkg::IDX_MASK3: read_byte = {software_post_enable_bit_ff, 7'h00};
            default: read_byte = 8'h00;
        endcase
    endfunction

    always_comb
    begin
        nxt_aw_held = aw_held_ff;
        nxt_aw_addr = aw_addr_ff;
        nxt_w_held = w_held_ff;
        nxt_w_byte = w_byte_ff;
        nxt_w_lane0 = w_lane0_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        if (s_axi_awvalid && awready_ff)
        begin
            nxt_aw_held = 1'b1;
            nxt_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_ff)
        begin
            nxt_w_held = 1'b1;
            nxt_w_byte = s_axi_wdata[7:0];
            nxt_w_lane0 = s_axi_wstrb[0];
        end
        if (wr_fire)
        begin
            nxt_aw_held = 1'b0;
            nxt_w_held = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = reg_hit(aw_addr_ff) ? ppic_pkg::RESP_OKAY : ppic_pkg::RESP_DECERR;
        end
        else if (bvalid_ff && s_axi_bready)
        begin
            nxt_bvalid = 1'b0;
        end
        nxt_awready = !nxt_aw_held && !nxt_bvalid;
        nxt_wready = !nxt_w_held && !nxt_bvalid;

        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (s_axi_arvalid && arready_ff)
        begin
            nxt_rvalid = 1'b1;
            nxt_rdata = {24'h000000, reg_hit(s_axi_araddr) ? read_byte(s_axi_araddr[9:2]) : 8'h00};
            nxt_rresp = reg_hit(s_axi_araddr) ? ppic_pkg::RESP_OKAY : ppic_pkg::RESP_DECERR;
        end
        else if (rvalid_ff && s_axi_rready)
        begin
            nxt_rvalid = 1'b0;
        end
        nxt_arready = !nxt_rvalid;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= '0;
            w_held_ff <= 1'b0;
            w_byte_ff <= 8'h00;
            w_lane0_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= ppic_pkg::RESP_OKAY;
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= ppic_pkg::RESP_OKAY;
        end
        else
        begin
            aw_held_ff <= nxt_aw_held;
            aw_addr_ff <= nxt_aw_addr;
            w_held_ff <= nxt_w_held;
            w_byte_ff <= nxt_w_byte;
            w_lane0_ff <= nxt_w_lane0;
            awready_ff <= nxt_awready;
            wready_ff <= nxt_wready;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            arready_ff <= nxt_arready;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Dispatch sequencer and flag register

    always_comb
    begin
        nxt_state = state_ff;
        nxt_step = step_ff;
        nxt_pc_snap = pc_snap_ff;
        nxt_flags_snap = flags_snap_ff;
        nxt_vector = vector_ff;
        nxt_flags = eff_flags;
        nxt_busy = 1'b0;
        nxt_push = 1'b0;
        nxt_push_data = push_data_ff;
        nxt_load = 1'b0;
        nxt_load_value = load_value_ff;
        unique case (state_ff)
            ppic_pkg::PPIC_IDLE:
            begin
                if (take)
                begin
                    nxt_state = ppic_pkg::PPIC_DISPATCH;
                    nxt_step = 4'h0;
                    nxt_busy = 1'b1;
                    nxt_pc_snap = cpu_program_counter;
                    nxt_flags_snap = eff_flags;
                    nxt_vector = {1'b0, sel_prio, 2'b00};
                end
            end
            ppic_pkg::PPIC_DISPATCH:
            begin
                // The core is stalled here, so its flag writes are not expected
                nxt_flags = flags_ff;
                nxt_busy = step_ff != ppic_pkg::STEP_LOAD_PC;
                nxt_step = step_ff + 4'h1;
                if (step_ff == ppic_pkg::STEP_PUSH_PC_HIGH)
                begin
                    nxt_push = 1'b1;
                    nxt_push_data = pc_snap_ff[15:8];
                end
                if (step_ff == ppic_pkg::STEP_PUSH_PC_LOW)
                begin
                    nxt_push = 1'b1;
                    nxt_push_data = pc_snap_ff[7:0];
                end
                if (step_ff == ppic_pkg::STEP_PUSH_FLAGS)
                begin
                    nxt_push = 1'b1;
                    nxt_push_data = flags_snap_ff;
                end
                if (step_ff == ppic_pkg::STEP_CLEAR_FLAGS)
                begin
                    nxt_flags = ppic_pkg::FLAGS_RESET;
                end
                if (step_ff == ppic_pkg::STEP_LOAD_PC)
                begin
                    nxt_load = 1'b1;
                    nxt_load_value = {8'h00, vector_ff};
                    nxt_state = ppic_pkg::PPIC_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            state_ff <= ppic_pkg::PPIC_IDLE;
            step_ff <= 4'h0;
            pc_snap_ff <= 16'h0000;
            flags_snap_ff <= ppic_pkg::FLAGS_RESET;
            vector_ff <= 8'h00;
            flags_ff <= ppic_pkg::FLAGS_RESET;
            busy_ff <= 1'b0;
            push_ff <= 1'b0;
            push_data_ff <= 8'h00;
            load_ff <= 1'b0;
            load_value_ff <= 16'h0000;
        end
        else
        begin
            state_ff <= nxt_state;
            step_ff <= nxt_step;
            pc_snap_ff <= nxt_pc_snap;
            flags_snap_ff <= nxt_flags_snap;
            vector_ff <= nxt_vector;
            flags_ff <= nxt_flags;
            busy_ff <= nxt_busy;
            push_ff <= nxt_push;
            push_data_ff <= nxt_push_data;
            load_ff <= nxt_load;
            load_value_ff <= nxt_load_value;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign cpu_flags = flags_ff;
    assign dispatch_busy = busy_ff;
    assign stack_push = push_ff;
    assign stack_push_data = push_data_ff;
    assign pc_load = load_ff;
    assign pc_load_value = load_value_ff;

endmodule // ppic_ctrl
`default_nettype wire

// ---- verification/ppic_core_model.sv ----
// Behavioural model of the CPU core that takes interrupts
`timescale 1ns/1ps
`default_nettype none
module ppic_core_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic dispatch_busy,
    input wire logic pc_load,
    input wire logic [15:0] pc_load_value,
    input wire logic ret_req,
    output logic cpu_instr_end,
    output logic [15:0] cpu_program_counter,
    output logic return_from_irq_instr,
    output logic [7:0] cpu_popped_flags
);
    logic [1:0] step_ff;
    logic ret_pend_ff;
    // Three-cycle instructions; none ends while the dispatch owns the core
    assign cpu_instr_end = (step_ff == 2'h2) && !dispatch_busy;
    assign return_from_irq_instr = ret_pend_ff && cpu_instr_end;
    assign cpu_popped_flags = 8'h01;
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            step_ff <= 2'h0;
            ret_pend_ff <= 1'h0;
            cpu_program_counter <= 16'h1234;
        end
        else
        begin
            if (ret_req) ret_pend_ff <= 1'h1;
            else if (return_from_irq_instr) ret_pend_ff <= 1'h0;
            if (pc_load) cpu_program_counter <= pc_load_value;
            else if (cpu_instr_end) cpu_program_counter <= cpu_program_counter + 16'h1;
            if (cpu_instr_end) step_ff <= 2'h0;
            else if (!dispatch_busy) step_ff <= step_ff + 2'h1;
        end
    end
endmodule // ppic_core_model
`default_nettype wire

// ---- verification/ppic_checker.sv ----
// Concurrent checks on the dispatch sequence and register read answers
`timescale 1ns/1ps
`default_nettype none
module ppic_checker (
    input wire logic clk,
    input wire logic resetn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic cpu_instr_end,
    input wire logic [15:0] cpu_program_counter,
    input wire logic [7:0] cpu_flags,
    input wire logic dispatch_busy,
    input wire logic stack_push,
    input wire logic [7:0] stack_push_data,
    input wire logic pc_load,
    input wire logic [15:0] pc_load_value
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    busy_length_a: assert property ($rose(dispatch_busy) |-> ##12 dispatch_busy ##1 !dispatch_busy)
        else $error("dispatch busy length wrong");
    take_at_end_a: assert property (!dispatch_busy && !cpu_instr_end |=> !dispatch_busy)
        else $error("dispatch began mid instruction");
    push_order_a: assert property ($rose(dispatch_busy) |-> ##1 stack_push [*3] ##1 !stack_push)
        else $error("push sequence wrong");
    push_pc_a: assert property ($rose(dispatch_busy) |-> ##1 stack_push_data == $past(cpu_program_counter[15:8], 2)
        ##1 stack_push_data == $past(cpu_program_counter[7:0], 3))
        else $error("pushed program counter wrong");
    flags_cleared_a: assert property ($rose(dispatch_busy) |-> ##4 (cpu_flags == 8'h00) [*8])
        else $error("flags not cleared in dispatch");
    load_after_busy_a: assert property ($fell(dispatch_busy) |-> pc_load)
        else $error("no vector load at dispatch end");
    vector_form_a: assert property (pc_load |-> pc_load_value[15:8] == 8'h00 && pc_load_value[1:0] == 2'h0)
        else $error("vector value malformed");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    cover property ($rose(dispatch_busy));
    cover property (pc_load && pc_load_value == 16'h0004);
    cover property (s_axi_arvalid && s_axi_arready);
endmodule // ppic_checker
bind ppic_ctrl ppic_checker chk_i (.*);
`default_nettype wire

// ---- verification/ppic_ctrl_tb.sv ----
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module ppic_ctrl_tb;
    logic clk = 1'h0;
    logic resetn = 1'h0;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0;
    logic [23:0] hw_event = 24'h0;
    logic [2:0] pins = 3'h0;
    logic flag_wr = 1'h0, ret_req = 1'h0;
    logic [7:0] flag_wdata = 8'h00;
    logic awready, wready, bvalid, arready, rvalid, instr_end, ret, busy, push, load;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] pc, load_value;
    logic [7:0] popped, flags, push_data;
    int n_fail = 0;
    int compares = 0;
    always #50 clk = ~clk;
    ppic_ctrl uut (.clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .hw_event(hw_event), .port_irq_pin(pins), .cpu_instr_end(instr_end),
        .cpu_program_counter(pc), .cpu_flag_wr(flag_wr), .cpu_flag_wdata(flag_wdata),
        .return_from_irq_instr(ret), .cpu_popped_flags(popped), .cpu_flags(flags),
        .dispatch_busy(busy), .stack_push(push), .stack_push_data(push_data), .pc_load(load),
        .pc_load_value(load_value));
    ppic_core_model core (.clk(clk), .resetn(resetn), .dispatch_busy(busy), .pc_load(load),
        .pc_load_value(load_value), .ret_req(ret_req), .cpu_instr_end(instr_end),
        .cpu_program_counter(pc), .return_from_irq_instr(ret), .cpu_popped_flags(popped));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        if (n_fail == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk);
        awaddr <= {2'h0, idx, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do
        begin
            @(posedge clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        bready <= 1'h0;
        chk("bresp", 32'h0, {30'h0, bresp});
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] r);
        @(posedge clk);
        araddr <= {2'h0, idx, 2'h0};
        arvalid <= 1'h1;
        rready <= 1'h1;
        do
        begin
            @(posedge clk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        rready <= 1'h0;
        chk("rdata", {24'h0, e}, rdata);
        chk("rresp", {30'h0, r}, {30'h0, rresp});
    endtask
    task automatic ev(input logic [23:0] m);
        @(posedge clk);
        hw_event <= m;
        @(posedge clk);
        hw_event <= 24'h0;
    endtask
    task automatic set_flags(input logic [7:0] v);
        @(posedge clk);
        flag_wr <= 1'h1;
        flag_wdata <= v;
        @(posedge clk);
        flag_wr <= 1'h0;
    endtask
    task automatic wait_load(input logic [15:0] v);
        int i;
        i = 0;
        do
        begin
            @(posedge clk);
            i++;
        end while (!load && i < 200);
        chk("vector", {16'h0, v}, load ? {16'h0, load_value} : 32'hffffffff);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge clk);
        resetn <= 1'h1;
        @(posedge clk);
        rd(8'hda, 8'h00, 2'h0);
        rd(8'hde, 8'h00, 2'h0);
        rd(8'h00, 8'h00, 2'h3);
        ev(24'hffffff);
        rd(8'hda, 8'hff, 2'h0);
        rd(8'hdb, 8'h7f, 2'h0);
        rd(8'hdc, 8'h16, 2'h0);
        wr(8'hda, 8'hfd);
        rd(8'hda, 8'hfd, 2'h0);
        wr(8'hda, 8'h00);
        wr(8'hdb, 8'h00);
        wr(8'hdc, 8'h00);
        wr(8'hde, 8'h80);
        wr(8'hdb, 8'h41);
        wr(8'hdb, 8'h00);
        rd(8'hdb, 8'h41, 2'h0);
        wr(8'hde, 8'h00);
        wr(8'hdb, 8'h00);
        pins <= 3'h4;
        repeat (6) @(posedge clk);
        rd(8'hdc, 8'h10, 2'h0);
        wr(8'hdc, 8'h00);
        repeat (4) @(posedge clk);
        rd(8'hdc, 8'h00, 2'h0);
        ev(24'h000003);
        wr(8'he0, 8'h02);
        chk("busy", 32'h0, {31'h0, busy});
        set_flags(8'h01);
        wait_load(16'h0008);
        chk("flags", 32'h0, {24'h0, flags});
        rd(8'hda, 8'h01, 2'h0);
        wr(8'he0, 8'h03);
        repeat (6) @(posedge clk);
        chk("busy", 32'h0, {31'h0, busy});
        set_flags(8'h01);
        wait_load(16'h0004);
        ev(24'h000002);
        @(posedge clk);
        ret_req <= 1'h1;
        @(posedge clk);
        ret_req <= 1'h0;
        wait_load(16'h0008);
        wr(8'he0, 8'h00);
        ev(24'h000004);
        rd(8'hda, 8'h04, 2'h0);
        stop_test();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        stop_test();
    end
endmodule // ppic_ctrl_tb
`default_nettype wire
